// file: rtl/oml_consts.vh
// constants for the operator menu and status led block
`ifndef OML_CONSTS_VH
`define OML_CONSTS_VH
// clock rate and times
`define OML_CLK_HZ        25000000
`define OML_TIMEOUT_MS    5000
`define OML_TICK_MS       250
// ticks of 250 ms per flash half period, and per menu timeout
`define OML_HALF_S_TICKS  1
`define OML_ONE_S_TICKS   2
`define OML_TWO_S_TICKS   4
`define OML_TIMEOUT_TICKS 20
// external reset held this many ticks means deactivate
`define OML_EXT_HOLD_TICKS 8
// menu positions, display letter codes
`define OML_POS_A 4'h0
`define OML_POS_B 4'h1
`define OML_POS_C 4'h2
`define OML_POS_E 4'h3
`define OML_POS_F 4'h4
`define OML_POS_O 4'h5
`define OML_POS_I 4'h6
`define OML_POS_T 4'h7
`define OML_POS_U 4'h8
`define OML_POS_V 4'h9
`define OML_POS_W 4'ha
`define OML_POS_X 4'hb
`define OML_POS_LAST 4'hb
// entry counts per position
`define OML_CNT_A 7'h01
`define OML_CNT_B 7'h02
`define OML_CNT_C 7'h03
`define OML_CNT_E 7'h63
`define OML_CNT_F 7'h03
`define OML_CNT_I 7'h04
`define OML_CNT_T 7'h05
`define OML_CNT_W 7'h10
`define OML_CNT_X 7'h03
// test entry indices
`define OML_TEST_ALARM    7'h01
`define OML_TEST_FAULT    7'h02
`define OML_TEST_PRESIG   7'h03
`define OML_TEST_ALARM2   7'h04
`endif

// file: rtl/oml_tick.v
// divider making a 250 ms enable pulse from the clock
`timescale 1ns/100ps
`include "oml_consts.vh"
module oml_tick
#(
   parameter CLK_HZ  = `OML_CLK_HZ,
   parameter TICK_MS = `OML_TICK_MS
)
(
   input  wire clock,
   input  wire rst,
   output reg  tick_ff
);
   localparam integer DIV = (CLK_HZ / 1000) * TICK_MS;
   reg [22:0] cnt_ff;
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         cnt_ff  <= 23'h000000;
         tick_ff <= 1'b0;
      end
      else if (cnt_ff == DIV[22:0] - 23'h000001)
      begin
         cnt_ff  <= 23'h000000;
         tick_ff <= 1'b1;
      end
      else
      begin
         cnt_ff  <= cnt_ff + 23'h000001;
         tick_ff <= 1'b0;
      end
   end
endmodule // oml_tick

// file: rtl/oml_panel.v
// operator menu state machine, reset handling and status led encoder
`timescale 1ns/100ps
`include "oml_consts.vh"
module oml_panel
#(
   parameter CLK_HZ          = `OML_CLK_HZ,
   parameter TIMEOUT_TICKS   = `OML_TIMEOUT_TICKS,
   parameter EXT_HOLD_TICKS  = `OML_EXT_HOLD_TICKS
)
(
   input  wire       clock,
   input  wire       rst,
   input  wire       key_step,
   input  wire       key_ok,
   input  wire       key_reset,
   input  wire       ext_reset_in,
   input  wire       event_pending,
   input  wire       cause_active,
   input  wire       sensor_off_panel,
   input  wire       pipe_delay_run,
   input  wire       pipe_fault,
   input  wire       tacho_missing,
   input  wire       other_fault,
   input  wire       presig1,
   input  wire       presig2,
   input  wire       presig3,
   input  wire       alarm,
   input  wire       det_dusty,
   input  wire       sens_dirty,
   input  wire       sens_faulty,
   input  wire [7:0] event_group,
   input  wire [7:0] fw_major,
   input  wire [7:0] fw_minor,
   input  wire [7:0] fw_patch,
   input  wire [7:0] flow_pct,
   input  wire [7:0] time_year,
   input  wire [7:0] time_month,
   input  wire [7:0] time_day,
   input  wire [7:0] time_hour,
   input  wire [7:0] time_minute,
   output reg        menu_active_ff,
   output reg  [3:0] disp_pos_ff,
   output reg  [9:0] disp_value_ff,
   output reg        disp_dot_ff,
   output reg  [6:0] event_slot_ff,
   output reg        limit_set_ff,
   output reg  [3:0] limit_class_ff,
   output reg  [6:0] limit_entry_ff,
   output reg        modules_logoff_ff,
   output reg        initial_reset_ff,
   output reg  [2:0] test_req_ff,
   output reg        time_write_ff,
   output reg  [2:0] time_field_ff,
   output reg  [7:0] time_value_ff,
   output reg        event_clear_ff,
   output reg        panel_reset_ff,
   output reg        device_inactive_ff,
   output reg        fan_run_ff,
   output reg        led_green_ff,
   output reg        led_red_ff,
   output reg        led_fault_ff,
   output reg        led_contam_ff
);
   // ==========================================
   // menu states
   localparam ST_IDLE  = 2'h0;
   localparam ST_POS   = 2'h1;
   localparam ST_ENTRY = 2'h2;
   localparam ST_EDIT  = 2'h3;
   reg  [1:0] state_ff;
   reg  [1:0] nxt_state;
   reg  [4:0] idle_cnt_ff;
   reg  [3:0] flash_ff;
   reg  [3:0] ext_cnt_ff;
   reg        ext_prev_ff;
   reg  [7:0] edit_ff;
   reg  [6:0] nxt_slot;
   reg  [7:0] nxt_edit;
   wire       tick;
   oml_tick #(.CLK_HZ(CLK_HZ), .TICK_MS(`OML_TICK_MS)) u_tick
   (
      .clock   (clock),
      .rst     (rst),
      .tick_ff (tick)
   );
   // entries per position
   function [6:0] pos_count;
      input [3:0] p;
      begin
         if (p == `OML_POS_A) pos_count = `OML_CNT_A;
         else if (p == `OML_POS_B) pos_count = `OML_CNT_B;
         else if (p == `OML_POS_C) pos_count = `OML_CNT_C;
         else if (p == `OML_POS_E) pos_count = `OML_CNT_E;
         else if (p == `OML_POS_F) pos_count = `OML_CNT_F;
         else if (p == `OML_POS_I) pos_count = `OML_CNT_I;
         else if (p == `OML_POS_T) pos_count = `OML_CNT_T;
         else if (p == `OML_POS_W) pos_count = `OML_CNT_W;
         else if (p == `OML_POS_X) pos_count = `OML_CNT_X;
         else pos_count = 7'h01;
      end
   endfunction
   // query positions take no settings
   function is_query;
      input [3:0] p;
      begin
         is_query = (p == `OML_POS_E) || (p == `OML_POS_F) || (p == `OML_POS_V);
      end
   endfunction
   // upper limit for a time field
   function [7:0] time_max;
      input [2:0] f;
      begin
         case (f)
            3'h0:    time_max = 8'd99;
            3'h1:    time_max = 8'd12;
            3'h2:    time_max = 8'd31;
            3'h3:    time_max = 8'd23;
            default: time_max = 8'd59;
         endcase
      end
   endfunction
   function [7:0] time_min;
      input [2:0] f;
      begin
         case (f)
            3'h0:    time_min = 8'd10;
            3'h1:    time_min = 8'd1;
            3'h2:    time_min = 8'd1;
            default: time_min = 8'd0;
         endcase
      end
   endfunction
   wire [2:0] tfield   = event_slot_ff[2:0] - 3'h1;
   wire [7:0] time_now = (tfield == 3'h0) ? time_year :
                         (tfield == 3'h1) ? time_month :
                         (tfield == 3'h2) ? time_day :
                         (tfield == 3'h3) ? time_hour : time_minute;
   wire       timeout  = (idle_cnt_ff == TIMEOUT_TICKS[4:0]);
   wire       any_key  = key_step | key_ok;
   // ==========================================
   // menu state machine
   always @*
   begin
      nxt_state = state_ff;
      nxt_slot  = event_slot_ff;
      nxt_edit  = edit_ff;
      case (state_ff)
         ST_IDLE:
            if (any_key)
               nxt_state = ST_POS;
         ST_POS:
            if (key_ok)
            begin
               nxt_state = ST_ENTRY;
               nxt_slot  = 7'h01;
            end
         ST_ENTRY:
            if (key_step)
               nxt_slot = (event_slot_ff >= pos_count(disp_pos_ff)) ? 7'h01 : event_slot_ff + 7'h01;
            else if (key_ok && disp_pos_ff == `OML_POS_T)
            begin
               nxt_state = ST_EDIT;
               nxt_edit  = time_now;
            end
            else if (key_ok)
               nxt_state = ST_IDLE;
         default:
            if (key_step)
               nxt_edit = (edit_ff >= time_max(tfield)) ? time_min(tfield) : edit_ff + 8'h01;
            else if (key_ok)
               nxt_state = ST_IDLE;
      endcase
      if (timeout)
         nxt_state = ST_IDLE;
   end
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state_ff          <= ST_IDLE;
         idle_cnt_ff       <= 5'h00;
         disp_pos_ff       <= `OML_POS_A;
         event_slot_ff     <= 7'h01;
         edit_ff           <= 8'h00;
         limit_set_ff      <= 1'b0;
         limit_class_ff    <= 4'h0;
         limit_entry_ff    <= 7'h00;
         modules_logoff_ff <= 1'b0;
         initial_reset_ff  <= 1'b0;
         test_req_ff       <= 3'h0;
         time_write_ff     <= 1'b0;
         time_field_ff     <= 3'h0;
         time_value_ff     <= 8'h00;
      end
      else
      begin
         state_ff          <= nxt_state;
         event_slot_ff     <= nxt_slot;
         edit_ff           <= nxt_edit;
         limit_set_ff      <= 1'b0;
         modules_logoff_ff <= 1'b0;
         initial_reset_ff  <= 1'b0;
         time_write_ff     <= 1'b0;
         if (state_ff == ST_IDLE || any_key)
            idle_cnt_ff <= 5'h00;
         else if (tick && !timeout)
            idle_cnt_ff <= idle_cnt_ff + 5'h01;
         if (state_ff == ST_IDLE || (state_ff == ST_POS && key_step))
            disp_pos_ff <= (state_ff == ST_IDLE || disp_pos_ff == `OML_POS_LAST) ? `OML_POS_A : disp_pos_ff + 4'h1;
         if (event_clear_ff)
            test_req_ff <= 3'h0;
         if (state_ff == ST_ENTRY && key_ok && !is_query(disp_pos_ff) && !timeout)
         begin
            if (disp_pos_ff == `OML_POS_O)
               modules_logoff_ff <= 1'b1;
            else if (disp_pos_ff == `OML_POS_U)
               initial_reset_ff <= 1'b1;
            else if (disp_pos_ff == `OML_POS_I)
               test_req_ff <= event_slot_ff[2:0];
            else if (disp_pos_ff != `OML_POS_T)
            begin
               limit_set_ff   <= 1'b1;
               limit_class_ff <= disp_pos_ff;
               limit_entry_ff <= event_slot_ff;
            end
         end
         if (state_ff == ST_EDIT && key_ok && !timeout)
         begin
            time_write_ff <= 1'b1;
            time_field_ff <= tfield;
            time_value_ff <= edit_ff;
         end
      end
   end
   // ==========================================
   // display
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         menu_active_ff <= 1'b0;
         disp_value_ff  <= 10'h000;
         disp_dot_ff    <= 1'b0;
      end
      else
      begin
         menu_active_ff <= (state_ff != ST_IDLE);
         disp_dot_ff    <= (state_ff == ST_IDLE) & flash_ff[0];
         if (state_ff == ST_EDIT)
            disp_value_ff <= {2'h0, edit_ff};
         else if (state_ff != ST_ENTRY)
            disp_value_ff <= 10'h000;
         else if (disp_pos_ff == `OML_POS_E)
            disp_value_ff <= {event_slot_ff[1:0], event_group};
         else if (disp_pos_ff == `OML_POS_F)
            disp_value_ff <= {2'h0, (event_slot_ff == 7'h01) ? fw_major :
                                   (event_slot_ff == 7'h02) ? fw_minor : fw_patch};
         else if (disp_pos_ff == `OML_POS_V)
            disp_value_ff <= {2'h0, flow_pct};
         else if (disp_pos_ff == `OML_POS_T)
            disp_value_ff <= {2'h0, time_now};
         else
            disp_value_ff <= {3'h0, event_slot_ff};
      end
   end
   // ==========================================
   // reset handling
   wire ext_pulse_end = ext_prev_ff && !ext_reset_in && (ext_cnt_ff < EXT_HOLD_TICKS[3:0]);
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         ext_prev_ff        <= 1'b0;
         ext_cnt_ff         <= 4'h0;
         device_inactive_ff <= 1'b0;
         event_clear_ff     <= 1'b0;
         panel_reset_ff     <= 1'b0;
         fan_run_ff         <= 1'b0;
      end
      else
      begin
         ext_prev_ff <= ext_reset_in;
         fan_run_ff  <= 1'b1;
         if (!ext_reset_in)
            ext_cnt_ff <= 4'h0;
         else if (tick && ext_cnt_ff != EXT_HOLD_TICKS[3:0])
            ext_cnt_ff <= ext_cnt_ff + 4'h1;
         device_inactive_ff <= ext_reset_in && (ext_cnt_ff == EXT_HOLD_TICKS[3:0]);
         event_clear_ff <= (key_reset || ext_pulse_end) && event_pending && !cause_active;
         panel_reset_ff <= 1'b0;
      end
   end
   // ==========================================
   // status leds, shared phase counter
   always @(posedge clock or posedge rst)
   begin
      if (rst)
         flash_ff <= 4'h0;
      else if (tick)
         flash_ff <= flash_ff + 4'h1;
   end
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         led_green_ff  <= 1'b0;
         led_red_ff    <= 1'b0;
         led_fault_ff  <= 1'b0;
         led_contam_ff <= 1'b0;
      end
      else
      begin
         led_green_ff <= 1'b1;
         if (alarm)
            led_red_ff <= 1'b1;
         else if (presig3)
            led_red_ff <= flash_ff[0];
         else if (presig2)
            led_red_ff <= flash_ff[1];
         else if (presig1)
            led_red_ff <= flash_ff[2];
         else
            led_red_ff <= 1'b0;
         if (pipe_fault || tacho_missing || other_fault)
            led_fault_ff <= 1'b1;
         else if (device_inactive_ff || sensor_off_panel)
            led_fault_ff <= flash_ff[0];
         else if (pipe_delay_run)
            led_fault_ff <= flash_ff[1];
         else
            led_fault_ff <= 1'b0;
         if (sens_faulty)
            led_contam_ff <= 1'b1;
         else if (sens_dirty)
            led_contam_ff <= flash_ff[0];
         else if (det_dusty)
            led_contam_ff <= flash_ff[1];
         else
            led_contam_ff <= 1'b0;
      end
   end
endmodule // oml_panel

// file: sim/oml_panel_asserts.sv
// checker on the operator panel ports
`timescale 1ns/100ps
module oml_panel_asserts
#(
   parameter CLK_HZ        = 25000000,
   parameter TIMEOUT_TICKS = 20
)
(
   input wire       clock,
   input wire       rst,
   input wire       key_step,
   input wire       key_ok,
   input wire       ext_reset_in,
   input wire       event_pending,
   input wire       cause_active,
   input wire       pipe_fault,
   input wire       tacho_missing,
   input wire       other_fault,
   input wire       alarm,
   input wire       sens_faulty,
   input wire       menu_active_ff,
   input wire       event_clear_ff,
   input wire       panel_reset_ff,
   input wire       device_inactive_ff,
   input wire       fan_run_ff,
   input wire       led_green_ff,
   input wire       led_red_ff,
   input wire       led_fault_ff,
   input wire       led_contam_ff,
   input wire       modules_logoff_ff,
   input wire       limit_set_ff,
   input wire [3:0] limit_class_ff,
   input wire [6:0] limit_entry_ff
);
   localparam LIM = TIMEOUT_TICKS * (CLK_HZ / 4) + 8;
   reg [31:0] idle_ff;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // =========================
   // cycles with menu open and no key
   always @(posedge clock or posedge rst)
      if (rst)
         idle_ff <= 32'h0;
      else if (!menu_active_ff || key_step || key_ok)
         idle_ff <= 32'h0;
      else
         idle_ff <= idle_ff + 32'h1;
   // =========================
   // assertions
   a_menu_timeout: assert property (idle_ff <= LIM)
      else $error("menu open past its timeout");
   a_green_lit: assert property (!$past(rst) |-> led_green_ff)
      else $error("green led dark while powered");
   a_fan_runs: assert property (!$past(rst) |-> fan_run_ff)
      else $error("fan stopped");
   a_panel_quiet: assert property (!panel_reset_ff)
      else $error("reset passed to the fire panel");
   a_clear_cause: assert property (event_clear_ff |-> $past(event_pending) && !$past(cause_active))
      else $error("event clear without a settled event");
   a_alarm_steady: assert property (alarm [*4] |-> led_red_ff)
      else $error("alarm led not steady");
   a_fault_steady: assert property ((pipe_fault || tacho_missing || other_fault) [*4] |-> led_fault_ff)
      else $error("fault led not steady");
   a_contam_steady: assert property (sens_faulty [*4] |-> led_contam_ff)
      else $error("contamination led not steady");
   a_logoff_pulse: assert property (modules_logoff_ff |=> !modules_logoff_ff)
      else $error("logoff longer than one cycle");
   a_limit_range: assert property (limit_set_ff && limit_class_ff < 4'h3 |->
      limit_entry_ff != 7'h0 && limit_entry_ff <= {3'h0, limit_class_ff} + 7'h01)
      else $error("limit entry outside its class");
   a_inactive_cause: assert property ($rose(device_inactive_ff) |-> $past(ext_reset_in))
      else $error("inactive without external reset");
   c_clear: cover property (event_clear_ff);
   c_logoff: cover property (modules_logoff_ff);
   c_limit_c: cover property (limit_set_ff && limit_entry_ff == 7'h03);
endmodule // oml_panel_asserts

bind oml_panel oml_panel_asserts #(.CLK_HZ(CLK_HZ), .TIMEOUT_TICKS(TIMEOUT_TICKS)) u_chk (.clock, .rst,
   .key_step, .key_ok, .ext_reset_in, .event_pending, .cause_active, .pipe_fault, .tacho_missing, .other_fault,
   .alarm, .sens_faulty, .menu_active_ff, .event_clear_ff, .panel_reset_ff, .device_inactive_ff, .fan_run_ff,
   .led_green_ff, .led_red_ff, .led_fault_ff, .led_contam_ff, .modules_logoff_ff, .limit_set_ff,
   .limit_class_ff, .limit_entry_ff);

// file: sim/oml_operator.sv
// operator keys and the panel's external reset line
`timescale 1ns/100ps
module oml_operator
(
   input  wire clock,
   output reg  key_step,
   output reg  key_ok,
   output reg  key_reset,
   output reg  ext_reset_in
);
   initial {key_step, key_ok, key_reset, ext_reset_in} = 4'h0;
   // =========================
   // one-cycle press, 0 step, 1 confirm, 2 reset
   task press(input integer k);
   begin
      @(negedge clock);
      if (k == 0)
         key_step = 1'b1;
      else if (k == 1)
         key_ok = 1'b1;
      else
         key_reset = 1'b1;
      @(negedge clock);
      {key_step, key_ok, key_reset} = 3'h0;
      repeat (4) @(negedge clock);
   end
   endtask
   // line held for n cycles
   task ext(input integer n);
   begin
      @(negedge clock);
      ext_reset_in = 1'b1;
      repeat (n) @(negedge clock);
      ext_reset_in = 1'b0;
      repeat (4) @(negedge clock);
   end
   endtask
endmodule // oml_operator

// file: sim/oml_panel_tb.sv
// self-checking bench for the operator panel
`timescale 1ns/100ps
`include "oml_consts.vh"
module oml_panel_tb;
   localparam HZ = 2000;
   localparam T  = HZ / 4;
   localparam [251:0] TBL = {{12'h040,2'h0,4'h2}, {12'h020,2'h0,4'h4}, {12'h010,2'h0,4'h8},
      {12'h008,2'h0,4'h0}, {12'h018,2'h0,4'h0}, {12'h800,2'h1,4'h8}, {12'h400,2'h1,4'h4},
      {12'h200,2'h1,4'h0}, {12'h100,2'h1,4'h0}, {12'h080,2'h1,4'h0}, {12'h480,2'h1,4'h0},
      {12'h004,2'h2,4'h4}, {12'h002,2'h2,4'h8}, {12'h001,2'h2,4'h0}};
   reg         clock, rst, event_pending, cause_active;
   reg  [11:0] st;
   reg  [79:0] vals;
   reg  [17:0] cs;
   reg  [3:0]  lcls;
   reg  [6:0]  lent;
   integer     n_fail = 0, checks_done = 0, n_clr = 0, n_off = 0, n_ini = 0, n_lim = 0, n_tw = 0, i, j, tg, hi;
   wire        key_step, key_ok, key_reset, ext_reset_in, sensor_off_panel, pipe_delay_run, pipe_fault;
   wire        tacho_missing, other_fault, presig1, presig2, presig3, alarm, det_dusty, sens_dirty, sens_faulty;
   wire        menu_active_ff, event_clear_ff, panel_reset_ff, device_inactive_ff, fan_run_ff, led_green_ff;
   wire        led_red_ff, led_fault_ff, led_contam_ff, modules_logoff_ff, initial_reset_ff, limit_set_ff;
   wire [3:0]  disp_pos_ff, limit_class_ff;
   wire [9:0]  disp_value_ff;
   wire [6:0]  event_slot_ff, limit_entry_ff;
   wire        disp_dot_ff, time_write_ff;
   wire [2:0]  test_req_ff, time_field_ff;
   wire [7:0]  time_value_ff;
   wire [3:0]  leds = {disp_dot_ff, led_contam_ff, led_fault_ff, led_red_ff};
   assign {sensor_off_panel, pipe_delay_run, pipe_fault, tacho_missing, other_fault, presig1, presig2, presig3,
      alarm, det_dusty, sens_dirty, sens_faulty} = st;
   oml_operator u_op (.clock, .key_step, .key_ok, .key_reset, .ext_reset_in);
   oml_panel #(.CLK_HZ(HZ), .TIMEOUT_TICKS(3), .EXT_HOLD_TICKS(2)) dut (.clock, .rst, .key_step, .key_ok,
      .key_reset, .ext_reset_in, .event_pending, .cause_active, .sensor_off_panel, .pipe_delay_run, .pipe_fault,
      .tacho_missing, .other_fault, .presig1, .presig2, .presig3, .alarm, .det_dusty, .sens_dirty, .sens_faulty,
      .event_group(vals[7:0]), .fw_major(vals[15:8]), .fw_minor(vals[23:16]), .fw_patch(vals[31:24]),
      .flow_pct(vals[39:32]), .time_year(vals[47:40]), .time_month(vals[55:48]), .time_day(vals[63:56]),
      .time_hour(vals[71:64]), .time_minute(vals[79:72]), .menu_active_ff, .disp_pos_ff, .disp_value_ff,
      .disp_dot_ff, .event_slot_ff, .limit_set_ff, .limit_class_ff, .limit_entry_ff, .modules_logoff_ff,
      .initial_reset_ff, .test_req_ff, .time_write_ff, .time_field_ff, .time_value_ff, .event_clear_ff,
      .panel_reset_ff, .device_inactive_ff, .fan_run_ff, .led_green_ff, .led_red_ff, .led_fault_ff,
      .led_contam_ff);
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // =========================
   // pulse counters
   always @(posedge clock)
   begin
      n_clr <= n_clr + event_clear_ff;
      n_off <= n_off + modules_logoff_ff;
      n_ini <= n_ini + initial_reset_ff;
      n_lim <= n_lim + limit_set_ff;
      n_tw  <= n_tw + time_write_ff;
      if (limit_set_ff)
      begin
         lcls <= limit_class_ff;
         lent <= limit_entry_ff;
      end
   end
   // =========================
   // helpers
   task chk(input ok, input [8*24-1:0] m);
   begin
      checks_done = checks_done + 1;
      if (ok !== 1'b1)
      begin
         n_fail = n_fail + 1;
         $display("wrong value at %0t: %0s", $time, m);
      end
   end
   endtask
   task go(input [3:0] p);
      integer k;
   begin
      for (k = 0; k <= p; k = k + 1)
         u_op.press(0);
   end
   endtask
   task meas(input [1:0] s, output integer t, output integer h);
      reg q;
   begin
      t = 0;
      h = 0;
      q = leds[s];
      repeat (8 * T)
      begin
         @(negedge clock);
         t = t + (leds[s] !== q);
         h = h + (leds[s] === 1'b1);
         q = leds[s];
      end
   end
   endtask
   task wrap_up;
   begin
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
   endtask
   initial
   begin
      repeat (100000) @(posedge clock);
      n_fail = n_fail + 1;
      $display("wrong value at %0t: run hung", $time);
      wrap_up;
   end
   // =========================
   // main sequence
   initial
   begin
      rst = 1'b1;
      st = 12'h000;
      vals = 80'h0;
      event_pending = 1'b0;
      cause_active = 1'b0;
      repeat (5) @(negedge clock);
      rst = 1'b0;
      repeat (3) @(negedge clock);
      chk(led_green_ff === 1'b1 && fan_run_ff === 1'b1, "power-up leds");
      go(0);
      chk(menu_active_ff === 1'b1 && disp_pos_ff === `OML_POS_A, "first position");
      repeat (T) @(negedge clock);
      chk(menu_active_ff === 1'b1, "menu closed early");
      repeat (3 * T) @(negedge clock);
      chk(menu_active_ff === 1'b0, "menu not timed out");
      go(`OML_POS_O);
      u_op.press(1);
      u_op.press(1);
      chk(n_off == 1, "module logoff");
      for (i = 0; i < 3; i = i + 1)
      begin
         go(i);
         u_op.press(1);
         for (j = 0; j < i; j = j + 1)
            u_op.press(0);
         u_op.press(1);
         chk(n_lim == i + 1 && lcls === i[3:0] && lent === i[6:0] + 7'h01, "limit set");
      end
      for (i = 1; i < 5; i = i + 1)
      begin
         go(`OML_POS_I);
         u_op.press(1);
         for (j = 1; j < i; j = j + 1)
            u_op.press(0);
         u_op.press(1);
         chk(test_req_ff === i[2:0], "test entry");
      end
      go(`OML_POS_U);
      u_op.press(1);
      u_op.press(1);
      chk(n_ini == 1, "initial reset");
      vals = {8'h3b, 8'h17, 8'h1f, 8'h0c, 8'h63, 8'hff, 8'h07, 8'h01, 8'h02, 8'h35};
      go(`OML_POS_E);
      u_op.press(1);
      chk(event_slot_ff === 7'h01, "newest slot");
      u_op.press(0);
      chk(event_slot_ff === 7'h02 && disp_value_ff === {2'h2, vals[7:0]}, "second slot");
      u_op.press(1);
      chk(n_lim == 3 && n_off == 1 && n_ini == 1, "query made an action");
      repeat (4 * T) @(negedge clock);
      go(`OML_POS_V);
      u_op.press(1);
      chk(disp_value_ff === 10'h0ff, "flow value");
      repeat (4 * T) @(negedge clock);
      go(`OML_POS_F);
      u_op.press(1);
      for (j = 0; j < 3; j = j + 1)
      begin
         chk(disp_value_ff === {2'h0, vals[8 + 8 * j +: 8]}, "firmware value");
         u_op.press(0);
      end
      u_op.press(1);
      go(`OML_POS_T);
      u_op.press(1);
      for (j = 0; j < 5; j = j + 1)
      begin
         chk(disp_value_ff === {2'h0, vals[40 + 8 * j +: 8]}, "time field shown");
         u_op.press(0);
      end
      u_op.press(1);
      u_op.press(0);
      chk(disp_value_ff === 10'h00a, "time edit wrap");
      u_op.press(1);
      chk(n_tw == 1 && time_field_ff === 3'h0 && time_value_ff === 8'h0a, "time write");
      event_pending = 1'b1;
      cause_active = 1'b1;
      u_op.press(2);
      chk(n_clr == 0, "reset with cause active");
      cause_active = 1'b0;
      u_op.press(2);
      chk(n_clr == 1 && panel_reset_ff === 1'b0 && test_req_ff === 3'h0, "key reset");
      u_op.ext(T / 2);
      chk(n_clr == 2 && device_inactive_ff === 1'b0, "short external reset");
      event_pending = 1'b0;
      u_op.press(2);
      chk(n_clr == 2, "reset with no event");
      fork
         u_op.ext(14 * T);
         begin
            repeat (4 * T) @(negedge clock);
            chk(device_inactive_ff === 1'b1 && fan_run_ff === 1'b1, "held reset");
            meas(1, tg, hi);
            chk(tg == 8 && hi == 4 * T, "inactive fault flash");
         end
      join
      chk(device_inactive_ff === 1'b0, "inactive after release");
      meas(3, tg, hi);
      chk(tg == 8 && hi == 4 * T, "idle dot flash");
      for (i = 0; i < 14; i = i + 1)
      begin
         cs = TBL[18 * (13 - i) +: 18];
         st = cs[17:6];
         repeat (8) @(negedge clock);
         meas(cs[5:4], tg, hi);
         chk(tg == cs[3:0] && hi == (cs[3:0] ? 4 * T : 8 * T), "led pattern");
      end
      st = 12'h000;
      wrap_up;
   end
endmodule // oml_panel_tb
